/* File: hdl/tsr_pkg.sv */
// constants, state type and helpers for the timing signal router
package tsr_pkg;

   localparam int N_TS      = 13;
   localparam int N_PIN     = 10;
   localparam int N_BUS     = 7;
   localparam int N_BUS_SIG = 8;
   localparam int SRC_W     = 5;
   localparam int PIN_SEL_W = 4;
   localparam int BUS_SEL_W = 3;
   localparam int SCAN_TS   = 0;
   localparam int STAR_LINE = 6;
   localparam int INT_TB_MHZ = 20;
   localparam int MCLK_MHZ   = 25;

   localparam logic [SRC_W-1:0] SRC_BUS0 = 5'h00;
   localparam logic [SRC_W-1:0] SRC_PIN0 = 5'h07;
   localparam logic [SRC_W-1:0] SRC_INT  = 5'h11;
   localparam logic [SRC_W-1:0] SRC_ALT  = 5'h12;

   localparam logic [N_TS-1:0]  RST_TS         = 13'h0000;
   localparam logic [N_PIN-1:0] RST_PIN        = 10'h000;
   localparam logic [N_BUS-1:0] RST_BUS        = 7'h00;
   localparam logic             RST_TB_BUS_SEL = 1'b0;
   localparam logic             RST_TB_EXPORT  = 1'b0;

   typedef struct packed {
      logic [N_TS-1:0]  ts;
      logic [N_PIN-1:0] pin_out;
      logic [N_PIN-1:0] pin_oe;
      logic [N_BUS-1:0] bus_out;
      logic [N_BUS-1:0] bus_oe;
      logic             tb_bus_sel;
      logic             tb_export;
   } tsr_state_t;

   // pin number carried by a pin source code
   function automatic logic [PIN_SEL_W-1:0] tsr_pin_idx(input logic [SRC_W-1:0] s);
      logic [SRC_W-1:0] d;
      d = s - SRC_PIN0;
      return d[PIN_SEL_W-1:0];
   endfunction

endpackage

/* File: hdl/tsr_src_mux.sv */
// source multiplexer for one timing signal
`timescale 1ns/10ps
`default_nettype none
module tsr_src_mux
(
   input  wire logic [tsr_pkg::N_BUS-1:0] bus_rx,
   input  wire logic [tsr_pkg::N_PIN-1:0] pin_rx,
   input  wire logic                      int_a,
   input  wire logic                      int_b,
   input  wire logic [tsr_pkg::SRC_W-1:0] sel,
   output logic                           y
);
   import tsr_pkg::*;

   // bus lines, any pin, or internal sources
   always_comb
   begin
      y = 1'b0;
      if (sel < SRC_PIN0)
      begin
         y = bus_rx[sel[2:0]];
      end
      else if (sel < SRC_INT)
      begin
         y = pin_rx[tsr_pin_idx(sel)];
      end
      else if (sel == SRC_INT)
      begin
         y = int_a;
      end
      else if (sel == SRC_ALT)
      begin
         y = int_b;
      end
   end
endmodule
`default_nettype wire

/* File: hdl/tsr_router.sv */
// timing signal router: source muxes, pin and bus drivers, timebase select
`timescale 1ns/10ps
`default_nettype none
module tsr_router
(
   input  wire logic                                          mclk,
   input  wire logic                                          rst_n,
   input  wire logic [tsr_pkg::N_PIN-1:0]                     function_input_pin_in,
   output logic      [tsr_pkg::N_PIN-1:0]                     function_input_pin_out,
   output logic      [tsr_pkg::N_PIN-1:0]                     function_input_pin_oe,
   input  wire logic [tsr_pkg::N_BUS-1:0]                     board_sync_bus_in,
   output logic      [tsr_pkg::N_BUS-1:0]                     board_sync_bus_out,
   output logic      [tsr_pkg::N_BUS-1:0]                     board_sync_bus_oe,
   input  wire logic                                          star_trigger_in,
   input  wire logic                                          backplane_mode,
   input  wire logic                                          scan_interval_terminal_count,
   input  wire logic                                          counter0_output,
   input  wire logic [tsr_pkg::N_TS-1:1]                      int_ts,
   input  wire logic [tsr_pkg::N_TS-1:0][tsr_pkg::SRC_W-1:0]  ts_src_sel,
   input  wire logic [tsr_pkg::N_PIN-1:0][tsr_pkg::PIN_SEL_W-1:0] pin_sig_sel,
   input  wire logic [tsr_pkg::N_PIN-1:0]                     pin_out_en,
   input  wire logic [tsr_pkg::N_BUS-1:0][tsr_pkg::BUS_SEL_W-1:0] bus_sig_sel,
   input  wire logic [tsr_pkg::N_BUS-1:0]                     bus_drive_en,
   input  wire logic                                          tb_use_bus,
   input  wire logic                                          tb_export_en,
   input  wire logic                                          int_timebase,
   input  wire logic                                          bus_timebase_in,
   output logic                                               bus_timebase_out,
   output logic                                               bus_timebase_oe,
   output logic                                               timebase_out,
   output logic                                               tb_bus_selected,
   output logic      [tsr_pkg::N_TS-1:0]                      timing_signal,
   output logic                                               scan_begin_pulse
);
   import tsr_pkg::*;

   tsr_state_t       st;
   tsr_state_t       next_st;
   logic [N_BUS-1:0] bus_rx;
   logic [N_TS-1:0]  mux_y;

   // pick one timing signal, zero for an unused index
   function automatic logic tsr_pick(input logic [N_TS-1:0] v, input logic [PIN_SEL_W-1:0] idx);
      logic r;
      r = 1'b0;
      if (idx < PIN_SEL_W'(N_TS))
      begin
         r = v[idx];
      end
      return r;
   endfunction

   // true for a source code that names a function pin
   function automatic logic tsr_is_pin(input logic [SRC_W-1:0] s);
      logic r;
      r = (s >= SRC_PIN0) && (s < SRC_INT);
      return r;
   endfunction

   // received bus lines; line 6 takes the star line on a backplane
   always_comb
   begin
      bus_rx = board_sync_bus_in;
      if (backplane_mode)
      begin
         bus_rx[STAR_LINE] = star_trigger_in;
      end
   end

   // scan start: bus, pins, interval count, counter0
   tsr_src_mux u_scan_mux
   (
      .bus_rx (bus_rx),
      .pin_rx (function_input_pin_in),
      .int_a  (scan_interval_terminal_count),
      .int_b  (counter0_output),
      .sel    (ts_src_sel[SCAN_TS]),
      .y      (mux_y[SCAN_TS])
   );

   // remaining timing signals, own internal source each
   for (genvar i = 1; i < N_TS; i++)
   begin : g_mux
      tsr_src_mux u_mux
      (
         .bus_rx (bus_rx),
         .pin_rx (function_input_pin_in),
         .int_a  (int_ts[i]),
         .int_b  (int_ts[i]),
         .sel    (ts_src_sel[i]),
         .y      (mux_y[i])
      );
   end

   always_comb
   begin
      next_st            = st;
      next_st.ts         = mux_y;
      next_st.tb_bus_sel = tb_use_bus;
      next_st.tb_export  = tb_export_en & ~tb_use_bus;
      for (int k = 0; k < N_PIN; k++)
      begin
         next_st.pin_oe[k]  = pin_out_en[k];
         next_st.pin_out[k] = tsr_pick(st.ts, pin_sig_sel[k]);
      end
      for (int j = 0; j < N_BUS; j++)
      begin
         next_st.bus_oe[j]  = bus_drive_en[j];
         next_st.bus_out[j] = tsr_pick(st.ts, {1'b0, bus_sig_sel[j]});
      end
      if (backplane_mode)
      begin
         next_st.bus_oe[STAR_LINE] = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         st.ts         <= RST_TS;
         st.pin_out    <= RST_PIN;
         st.pin_oe     <= RST_PIN;
         st.bus_out    <= RST_BUS;
         st.bus_oe     <= RST_BUS;
         st.tb_bus_sel <= RST_TB_BUS_SEL;
         st.tb_export  <= RST_TB_EXPORT;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign timing_signal          = st.ts;
   assign scan_begin_pulse       = st.ts[SCAN_TS];
   assign function_input_pin_out = st.pin_out;
   assign function_input_pin_oe  = st.pin_oe;
   assign board_sync_bus_out     = st.bus_out;
   assign board_sync_bus_oe      = st.bus_oe;
   assign tb_bus_selected        = st.tb_bus_sel;
   assign bus_timebase_out       = int_timebase;
   assign bus_timebase_oe        = st.tb_export & ~st.tb_bus_sel;
   // clock level, passed without resampling
   assign timebase_out           = st.tb_bus_sel ? bus_timebase_in : int_timebase;

   // checking helpers
   logic exp_pin_ts5;
   logic exp_drive_pin5;
   logic src5_is_pin;
   logic exp_scan_pin;
   assign src5_is_pin    = tsr_is_pin(ts_src_sel[5]);
   assign exp_scan_pin   = tsr_is_pin(ts_src_sel[SCAN_TS])
                           && function_input_pin_in[tsr_pin_idx(ts_src_sel[SCAN_TS])];
   assign exp_pin_ts5    = function_input_pin_in[tsr_pin_idx(ts_src_sel[5])];
   assign exp_drive_pin5 = tsr_pick(st.ts, pin_sig_sel[5]);

   chk_scan_internal: assert property (@(posedge mclk) disable iff (!rst_n)
      (ts_src_sel[SCAN_TS] == SRC_INT) |=> (scan_begin_pulse == $past(scan_interval_terminal_count)))
      else $error("scan start does not follow interval count");

   chk_scan_counter: assert property (@(posedge mclk) disable iff (!rst_n)
      (ts_src_sel[SCAN_TS] == SRC_ALT) |=> (scan_begin_pulse == $past(counter0_output)))
      else $error("scan start does not follow counter0");

   chk_signal_pin: assert property (@(posedge mclk) disable iff (!rst_n)
      src5_is_pin |=> (timing_signal[5] == $past(exp_pin_ts5)))
      else $error("timing signal does not follow its selected pin");

   chk_shared_pin: assert property (@(posedge mclk) disable iff (!rst_n)
      (ts_src_sel[1] == ts_src_sel[11] && tsr_is_pin(ts_src_sel[1]))
      |=> (timing_signal[1] == timing_signal[11]))
      else $error("two signals on one pin differ");

   chk_pin_drive: assert property (@(posedge mclk) disable iff (!rst_n)
      pin_out_en[5] |=> function_input_pin_oe[5] && (function_input_pin_out[5] == $past(exp_drive_pin5)))
      else $error("pin driver does not carry its timing signal");

   chk_tb_bus: assert property (@(posedge mclk) disable iff (!rst_n)
      tb_use_bus |=> tb_bus_selected && (timebase_out == bus_timebase_in))
      else $error("bus timebase not selected");

   chk_tb_export: assert property (@(posedge mclk) disable iff (!rst_n)
      bus_timebase_oe |-> ($past(tb_export_en) && !$past(tb_use_bus)))
      else $error("timebase driven without internal selection");

   chk_tb_exclusive: assert property (@(posedge mclk) disable iff (!rst_n)
      tb_use_bus ##1 tb_use_bus |-> !bus_timebase_oe)
      else $error("timebase driver on while receiving");

   chk_reset_tb: assert property (@(posedge mclk) disable iff (!rst_n)
      !$past(rst_n) |-> (!bus_timebase_oe && !tb_bus_selected && (timebase_out == int_timebase)))
      else $error("timebase state wrong after reset");

   chk_bus_line: assert property (@(posedge mclk) disable iff (!rst_n)
      (bus_drive_en[2] && bus_sig_sel[2] == 3'h3) |=> board_sync_bus_oe[2] ##0
      (board_sync_bus_out[2] == $past(timing_signal[3])))
      else $error("bus line does not carry its timing signal");

   chk_star_rx: assert property (@(posedge mclk) disable iff (!rst_n)
      (backplane_mode && ts_src_sel[SCAN_TS] == 5'h06) |=> (scan_begin_pulse == $past(star_trigger_in)))
      else $error("star trigger not received on line 6");

   chk_scan_unused: assert property (@(posedge mclk) disable iff (!rst_n)
      (ts_src_sel[SCAN_TS] > SRC_ALT)
      |=> !scan_begin_pulse)
      else $error("unused source code does not give zero");

   chk_ts_internal: assert property (@(posedge mclk) disable iff (!rst_n)
      (ts_src_sel[7] == SRC_INT)
      |=> (timing_signal[7] == $past(int_ts[7])))
      else $error("timing signal does not follow its internal source");

   chk_scan_pin_any: assert property (@(posedge mclk) disable iff (!rst_n)
      tsr_is_pin(ts_src_sel[SCAN_TS])
      |=> (scan_begin_pulse == $past(exp_scan_pin)))
      else $error("scan start does not follow its selected pin");

   chk_scan_shared: assert property (@(posedge mclk) disable iff (!rst_n)
      (ts_src_sel[SCAN_TS] == ts_src_sel[5] && tsr_is_pin(ts_src_sel[5]))
      |=> (scan_begin_pulse == timing_signal[5]))
      else $error("scan start and signal on one pin differ");

   chk_pin_oe_off: assert property (@(posedge mclk) disable iff (!rst_n)
      !pin_out_en[5]
      |=> !function_input_pin_oe[5])
      else $error("pin driver on without enable");

   chk_pin_unused: assert property (@(posedge mclk) disable iff (!rst_n)
      (pin_sig_sel[9] >= PIN_SEL_W'(N_TS))
      |=> !function_input_pin_out[9])
      else $error("pin drives a value for an unused signal index");

   chk_export_on: assert property (@(posedge mclk) disable iff (!rst_n)
      (tb_export_en && !tb_use_bus)
      |=> bus_timebase_oe)
      else $error("timebase export not enabled");

   chk_tb_out_level: assert property (@(posedge mclk) disable iff (!rst_n)
      bus_timebase_oe
      |-> (bus_timebase_out == int_timebase))
      else $error("exported timebase is not the internal one");

   chk_tb_internal: assert property (@(posedge mclk) disable iff (!rst_n)
      !tb_use_bus
      |=> (!tb_bus_selected && (timebase_out == int_timebase)))
      else $error("internal timebase not selected");

   chk_reset_regs: assert property (@(posedge mclk) disable iff (!rst_n)
      !$past(rst_n)
      |-> (timing_signal == '0 && function_input_pin_oe == '0 && board_sync_bus_oe == '0))
      else $error("outputs not cleared after reset");

   chk_scan_bus: assert property (@(posedge mclk) disable iff (!rst_n)
      (!backplane_mode && ts_src_sel[SCAN_TS] == SRC_BUS0)
      |=> (scan_begin_pulse == $past(board_sync_bus_in[0])))
      else $error("scan start does not follow bus line 0");

   chk_bus_oe_on: assert property (@(posedge mclk) disable iff (!rst_n)
      (!backplane_mode && bus_drive_en[STAR_LINE])
      |=> board_sync_bus_oe[STAR_LINE])
      else $error("bus line 6 driver not enabled");

   chk_star_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
      (!backplane_mode && ts_src_sel[SCAN_TS] == SRC_BUS0 + SRC_W'(STAR_LINE))
      |=> (scan_begin_pulse == $past(board_sync_bus_in[STAR_LINE])))
      else $error("line 6 not taken from the bus outside backplane mode");

   chk_line_pass: assert property (@(posedge mclk) disable iff (!rst_n)
      (backplane_mode && ts_src_sel[SCAN_TS] == SRC_BUS0 + SRC_W'(STAR_LINE - 1))
      |=> (scan_begin_pulse == $past(board_sync_bus_in[STAR_LINE - 1])))
      else $error("backplane line 5 not passed through");

   chk_star_no_drive: assert property (@(posedge mclk) disable iff (!rst_n)
      backplane_mode
      |=> !board_sync_bus_oe[STAR_LINE])
      else $error("star line driven in backplane mode");

   chk_tb_never_both: assert property (@(posedge mclk) disable iff (!rst_n)
      !(bus_timebase_oe && tb_bus_selected))
      else $error("timebase driven while receiving it");

   cov_scan_from_pin: cover property (@(posedge mclk) disable iff (!rst_n)
      (ts_src_sel[SCAN_TS] == SRC_PIN0) ##1 scan_begin_pulse);

   cov_tb_export: cover property (@(posedge mclk) disable iff (!rst_n)
      bus_timebase_oe);

   cov_bus_tb: cover property (@(posedge mclk) disable iff (!rst_n)
      tb_bus_selected ##1 !tb_bus_selected);

   cov_pin_drive: cover property (@(posedge mclk) disable iff (!rst_n)
      function_input_pin_oe[5] && function_input_pin_out[5]);

   cov_star_rx: cover property (@(posedge mclk) disable iff (!rst_n)
      backplane_mode && scan_begin_pulse);
endmodule
`default_nettype wire

/* File: tb/tsr_far_side.sv */
// far-side model: external circuitry and other boards on the sync bus
`timescale 1ns/10ps
`default_nettype none
module tsr_far_side
(
   input  wire logic                      mclk,
   input  wire logic [tsr_pkg::N_PIN-1:0] pin_ext,
   input  wire logic [tsr_pkg::N_PIN-1:0] pin_out,
   input  wire logic [tsr_pkg::N_PIN-1:0] pin_oe,
   input  wire logic [tsr_pkg::N_BUS-1:0] bus_ext,
   input  wire logic [tsr_pkg::N_BUS-1:0] bus_out,
   input  wire logic [tsr_pkg::N_BUS-1:0] bus_oe,
   input  wire logic                      tb_out,
   input  wire logic                      tb_oe,
   output logic      [tsr_pkg::N_PIN-1:0] pin_wire,
   output logic      [tsr_pkg::N_BUS-1:0] bus_wire,
   output logic                           tb_wire
);
   logic foreign_tb = 1'b0;
   // other board exports its timebase; our driver wins while tb_oe is set
   always @(posedge mclk) foreign_tb <= !foreign_tb;
   assign pin_wire = (pin_oe & pin_out) | (~pin_oe & pin_ext);
   // line 6 is an ordinary bus line here; the star trigger reaches the router on its own input
   assign bus_wire = (bus_oe & bus_out) | (~bus_oe & bus_ext);
   assign tb_wire  = tb_oe ? tb_out : foreign_tb;
endmodule
`default_nettype wire

/* File: tb/tsr_router_bench.sv */
// self-checking bench for the timing signal router
`timescale 1ns/10ps
`default_nettype none
module tsr_router_bench;
   import tsr_pkg::*;
   logic                              mclk = 1'b0, rst_n = 1'b0;
   logic [N_PIN-1:0]                  pin_ext = '0, pin_w, pin_out, pin_oe, pin_en = '0;
   logic [N_BUS-1:0]                  bus_ext = '0, bus_w, bus_out, bus_oe, bus_en = '0;
   logic                              star = 1'b0, bp = 1'b0, sitc = 1'b0, c0 = 1'b0;
   logic [N_TS-1:1]                   int_ts = '0;
   logic [N_TS-1:0][SRC_W-1:0]        src_sel = '0;
   logic [N_PIN-1:0][PIN_SEL_W-1:0]   pin_sel = '0;
   logic [N_BUS-1:0][BUS_SEL_W-1:0]   bus_sel = '0;
   logic                              use_bus = 1'b0, exp_en = 1'b0, int_tb = 1'b0;
   logic                              tb_w, tb_out, tb_oe, tb_mux, tb_sel, scan;
   logic [N_TS-1:0]                   ts;
   int                                miscompares = 0, checked = 0, cycles = 0;
   tsr_router tsr_router_inst (.mclk(mclk), .rst_n(rst_n), .function_input_pin_in(pin_w),
      .function_input_pin_out(pin_out), .function_input_pin_oe(pin_oe), .board_sync_bus_in(bus_w),
      .board_sync_bus_out(bus_out), .board_sync_bus_oe(bus_oe), .star_trigger_in(star),
      .backplane_mode(bp), .scan_interval_terminal_count(sitc), .counter0_output(c0),
      .int_ts(int_ts), .ts_src_sel(src_sel), .pin_sig_sel(pin_sel), .pin_out_en(pin_en),
      .bus_sig_sel(bus_sel), .bus_drive_en(bus_en), .tb_use_bus(use_bus), .tb_export_en(exp_en),
      .int_timebase(int_tb), .bus_timebase_in(tb_w), .bus_timebase_out(tb_out),
      .bus_timebase_oe(tb_oe), .timebase_out(tb_mux), .tb_bus_selected(tb_sel),
      .timing_signal(ts), .scan_begin_pulse(scan));
   tsr_far_side tsr_far_side_inst (.mclk(mclk), .pin_ext(pin_ext), .pin_out(pin_out),
      .pin_oe(pin_oe), .bus_ext(bus_ext), .bus_out(bus_out), .bus_oe(bus_oe), .tb_out(tb_out),
      .tb_oe(tb_oe), .pin_wire(pin_w), .bus_wire(bus_w), .tb_wire(tb_w));
   initial
   begin
      forever #20 mclk = !mclk;
   end
   task automatic test_done;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // one source bit set (or cleared among all set) in code order
   task automatic drive_one(input int c, input logic v);
      logic [18:0] m;
      m = 19'h1 << c;
      if (!v) m = ~m;
      bus_ext = m[6:0];
      pin_ext = m[16:7];
      sitc = m[17];
      c0 = m[18];
   endtask
   task automatic chk_idle;
      chk("pin_oe", 16'h0000, 16'(pin_oe));
      chk("bus_oe", 16'h0000, 16'(bus_oe));
      chk("tb_oe", 16'h0000, 16'(tb_oe));
      chk("tb_sel", 16'h0000, 16'(tb_sel));
   endtask
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         miscompares++;
         test_done();
      end
   end
   initial
   begin
      logic [N_TS-1:0] e;
      tick(10);
      chk_idle();
      rst_n = 1'b1;
      for (int i = 0; i < N_TS; i++) src_sel[i] = SRC_PIN0 + 5'(i % N_PIN);
      for (int p = 0; p < 2; p++)
      begin
         pin_ext = p[0] ? 10'h14A : 10'h2B5;
         tick(1);
         for (int i = 0; i < N_TS; i++) e[i] = pin_ext[i % N_PIN];
         chk("ts_pins", 16'(e), 16'(ts));
      end
      for (int c = 0; c < 20; c++)
      begin
         src_sel[0] = 5'(c);
         for (int v = 0; v < 2; v++)
         begin
            drive_one(c, v[0]);
            tick(1);
            chk("scan", 16'(v[0] && c < 19), 16'(scan));
         end
      end
      src_sel = {{(N_TS-1){SRC_INT}}, SRC_ALT};
      int_ts = 12'hA5C;
      c0 = 1'b1;
      for (int k = 0; k < N_PIN; k++) pin_sel[k] = 4'(k);
      pin_sel[9] = 4'hD;
      pin_en = 10'h3FF;
      for (int j = 0; j < N_BUS; j++) bus_sel[j] = 3'(j + 1);
      bus_en = 7'h7F;
      e = {int_ts, c0};
      tick(1);
      chk("ts_int", 16'(e), 16'(ts));
      chk("pin_oe", 16'h03FF, 16'(pin_oe));
      chk("bus_oe", 16'h007F, 16'(bus_oe));
      tick(1);
      chk("pin_out", 16'(e[8:0]), 16'(pin_out));
      chk("bus_out", 16'(e[7:1]), 16'(bus_out));
      bp = 1'b1;
      src_sel[0] = SRC_BUS0 + 5'h06;
      star = 1'b1;
      bus_ext = 7'h00;
      tick(1);
      chk("bus_oe_bp", 16'h003F, 16'(bus_oe));
      chk("scan_star", 16'h0001, 16'(scan));
      star = 1'b0;
      bus_ext = 7'h40;
      tick(1);
      chk("scan_star", 16'h0000, 16'(scan));
      bus_en = 7'h00;
      src_sel[0] = SRC_BUS0 + 5'h05;
      bus_ext = 7'h20;
      tick(2);
      chk("bus_oe_off", 16'h0000, 16'(bus_oe));
      chk("scan_line5", 16'h0001, 16'(scan));
      exp_en = 1'b1;
      tick(1);
      chk("tb_oe", 16'h0001, 16'(tb_oe));
      chk("tb_sel", 16'h0000, 16'(tb_sel));
      for (int v = 0; v < 2; v++)
      begin
         int_tb = v[0];
         tick(1);
         chk("tb_mux", 16'(v[0]), 16'(tb_mux));
         chk("tb_out", 16'(v[0]), 16'(tb_out));
      end
      use_bus = 1'b1;
      tick(1);
      chk("tb_oe", 16'h0000, 16'(tb_oe));
      chk("tb_sel", 16'h0001, 16'(tb_sel));
      for (int v = 0; v < 2; v++)
      begin
         tick(1);
         chk("tb_mux", 16'(tb_w), 16'(tb_mux));
      end
      use_bus = 1'b0;
      tick(1);
      chk("tb_sel", 16'h0000, 16'(tb_sel));
      chk("tb_oe", 16'h0001, 16'(tb_oe));
      chk("tb_mux", 16'h0001, 16'(tb_mux));
      int_tb = 1'b0;
      tick(1);
      chk("tb_mux", 16'h0000, 16'(tb_mux));
      rst_n = 1'b0;
      tick(2);
      chk_idle();
      test_done();
   end
endmodule
`default_nettype wire
